/* hw/sfk_flow_kbd.sv */
/*
  Serial flow control and keyboard transmit block: receive queue with
  water-mark pause/resume, XON/XOFF and secondary RTS, keystroke queue,
  auto repeat, control key codes and break generation. AXI4-Lite slave.
  Assumes receive, printer and keyboard strobes come from mclk logic;
  printer fault lines are asynchronous pins.
*/
// Added by the designer: the AXI4-Lite register port and the address map.
`default_nettype none
module sfk_flow_kbd
  import sfk_pkg::*;
#(
  parameter logic [CNT_W-1:0] BRK_SHORT = CNT_W'(BRK_SHORT_CYC),
  parameter logic [CNT_W-1:0] BRK_LONG = CNT_W'(BRK_LONG_CYC),
  parameter logic [CNT_W-1:0] REP_DELAY = CNT_W'(REP_DELAY_CYC),
  parameter logic [CNT_W-1:0] REP_START = CNT_W'(REP_START_CYC),
  parameter logic [CNT_W-1:0] REP_END = CNT_W'(REP_END_CYC),
  parameter logic [CNT_W-1:0] REP_STEP = CNT_W'(REP_STEP_CYC),
  parameter logic [CNT_W-1:0] TONE_HALF = CNT_W'(TONE_HALF_CYC),
  parameter logic [CNT_W-1:0] TONE_LEN = CNT_W'(TONE_LEN_CYC)
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxParityErr,
  output logic [7:0] prnData,
  output logic prnValid,
  input wire logic prnFetch,
  input wire logic paperOut,
  input wire logic headJam,
  input wire logic coverOpen,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic txBreak,
  output logic srts,
  input wire logic keyPress,
  input wire logic [7:0] keyCode,
  input wire logic keyRepeatable,
  input wire logic keyIsReturn,
  input wire logic lastKeyHeld,
  input wire logic breakPress,
  input wire logic shiftHeld,
  output logic toneOut
);
  logic [CTL_W-1:0] ctrl;
  logic [7:0] turnChar;
  logic [CTL_W-1:0] ctrlPrev;
  logic awHeld, wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [2:0] faultMeta, faultSync;
  logic [7:0] rxMem [RXQ_DEPTH];
  logic [9:0] rxWr, rxRd, rxCount;
  logic lostPend;
  logic [7:0] kqMem [KQ_DEPTH];
  logic [3:0] kqWr, kqRd;
  logic [4:0] kqCount;
  logic wmPause, sentPause;
  logic pendLf, pendTurn;
  logic repeating, lastRep;
  logic [7:0] lastCode;
  logic [CNT_W-1:0] holdCnt, repTimer, repPeriod, brkCnt, toneCnt, toneDiv;

  // Decoded settings
  logic txEn, xonEn, restraint, setupMode, notReady, pauseReq, kqFlush;
  assign txEn = ctrl[CTL_TXEN];
  assign xonEn = ctrl[CTL_XONEN];
  assign restraint = ctrl[CTL_SECCH] & ctrl[CTL_MODEM];
  assign setupMode = ctrl[CTL_SETUP];
  assign notReady = |faultSync | setupMode;
  assign pauseReq = wmPause | notReady;
  assign kqFlush = (ctrl[CTL_SETUP] != ctrlPrev[CTL_SETUP]) | (ctrl[CTL_LINE] != ctrlPrev[CTL_LINE]) | breakPress;

  // AXI4-Lite write channel
  logic doWrite;
  assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
  always_ff @(posedge mclk) begin
    if (srst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= ~awHeld & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~wHeld & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr == REG_CTRL || awAddr == REG_TURN || awAddr == REG_STAT) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl <= CTRL_RST;
      turnChar <= TURN_RST;
      ctrlPrev <= CTRL_RST;
    end else begin
      ctrlPrev <= ctrl;
      if (doWrite) begin
        if (awAddr == REG_CTRL) begin
          if (wStrb[0]) ctrl[7:0] <= wData[7:0];
          if (wStrb[1]) ctrl[CTL_W-1:8] <= wData[CTL_W-1:8];
        end else if (awAddr == REG_TURN) begin
          if (wStrb[0]) turnChar <= wData[7:0];
        end
      end
    end
  end

  // AXI4-Lite read channel
  logic [31:0] statWord;
  always_comb begin
    statWord = 32'h0000_0000;
    statWord[ST_RXCNT +: 10] = rxCount;
    statWord[ST_KQCNT +: 5] = kqCount;
    statWord[ST_PAUSE] = sentPause;
    statWord[ST_SRTS] = srts;
    statWord[ST_BRK] = txBreak;
    statWord[ST_REP] = repeating;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == REG_CTRL) begin
          s_axi_rdata <= {22'h000000, ctrl};
        end else if (s_axi_araddr == REG_TURN) begin
          s_axi_rdata <= {24'h000000, turnChar};
        end else if (s_axi_araddr == REG_STAT) begin
          s_axi_rdata <= statWord;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Printer fault pins synchronised
  always_ff @(posedge mclk) begin
    if (srst) begin
      faultMeta <= 3'h0;
      faultSync <= 3'h0;
    end else begin
      faultMeta <= {paperOut, headJam, coverOpen};
      faultSync <= faultMeta;
    end
  end

  // Receive queue
  logic rxKeep, rxFull, rxPush, rxPop;
  logic [7:0] rxIn;
  assign rxKeep = rxValid & (rxData != CH_NUL) & (rxData != CH_DEL);
  assign rxFull = rxCount == RX_FULL;
  assign rxPop = (rxCount != 10'h000) & (~prnValid | prnFetch);
  assign rxPush = ~rxFull & (lostPend | rxKeep);
  assign rxIn = (lostPend | rxParityErr) ? CH_SUB : rxData;
  always_ff @(posedge mclk) begin
    if (rxPush) rxMem[rxWr] <= rxIn;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxWr <= 10'h000;
      rxRd <= 10'h000;
      rxCount <= 10'h000;
      lostPend <= 1'b0;
    end else begin
      if (rxPush) rxWr <= (rxWr == RX_LAST) ? 10'h000 : rxWr + 10'h001;
      if (rxPop) rxRd <= (rxRd == RX_LAST) ? 10'h000 : rxRd + 10'h001;
      rxCount <= rxCount + {9'h000, rxPush} - {9'h000, rxPop};
      if (rxKeep & (rxFull | lostPend)) lostPend <= 1'b1;
      else if (rxPush) lostPend <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      prnValid <= 1'b0;
      prnData <= 8'h00;
    end else if (rxPop) begin
      prnValid <= 1'b1;
      prnData <= rxMem[rxRd];
    end else if (prnFetch) begin
      prnValid <= 1'b0;
    end
  end

  // Water marks with hysteresis
  logic [9:0] lowMark, highMark;
  assign lowMark = ctrl[CTL_BUFLG] ? LOW_LARGE : LOW_SMALL;
  assign highMark = ctrl[CTL_BUFLG] ? HIGH_LARGE : HIGH_SMALL;
  always_ff @(posedge mclk) begin
    if (srst) begin
      wmPause <= 1'b0;
    end else if (~(xonEn | restraint)) begin
      wmPause <= 1'b0;
    end else if (rxCount > highMark) begin
      wmPause <= 1'b1;
    end else if (rxCount < lowMark) begin
      wmPause <= 1'b0;
    end
  end

  // secondary RTS high means go ahead
  always_ff @(posedge mclk) begin
    if (srst) srts <= 1'b1;
    else srts <= ~(restraint & pauseReq);
  end

  // Keystroke queue
  logic keyTake, repPush, kqPush, kqPop, flowSend, kqFull;
  logic [7:0] kqIn;
  assign kqFull = kqCount == KQ_FULL;
  assign keyTake = keyPress & ~repeating & ~pendLf & ~pendTurn & ~kqFlush;
  always_comb begin
    kqPush = 1'b0;
    kqIn = keyCode;
    if (kqFlush) begin
      kqPush = 1'b0;
    end else if (pendLf) begin
      kqPush = 1'b1;
      kqIn = CH_LF;
    end else if (pendTurn) begin
      kqPush = 1'b1;
      kqIn = turnChar;
    end else if (repPush) begin
      kqPush = 1'b1;
      kqIn = lastCode;
    end else if (keyTake) begin
      kqPush = 1'b1;
    end
    if (kqFull) kqPush = 1'b0;
  end
  assign flowSend = txEn & xonEn & (pauseReq != sentPause) & ~txBreak;
  // drained at once when enabled, held otherwise
  assign kqPop = (kqCount != 5'h00) & txEn & ~txBreak & ~flowSend & (~txValid | txReady) & ~kqFlush;
  always_ff @(posedge mclk) begin
    if (kqPush) kqMem[kqWr] <= kqIn;
  end
  always_ff @(posedge mclk) begin
    if (srst | kqFlush) begin
      kqWr <= 4'h0;
      kqRd <= 4'h0;
      kqCount <= 5'h00;
    end else begin
      if (kqPush) kqWr <= kqWr + 4'h1;
      if (kqPop) kqRd <= kqRd + 4'h1;
      kqCount <= kqCount + {4'h0, kqPush} - {4'h0, kqPop};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst | kqFlush) begin
      pendLf <= 1'b0;
      pendTurn <= 1'b0;
    end else if (keyTake & keyIsReturn & ~kqFull) begin
      pendLf <= ctrl[CTL_NEWLN];
      pendTurn <= ctrl[CTL_CHDX];
    end else if (~kqFull) begin
      if (pendLf) pendLf <= 1'b0;
      else pendTurn <= 1'b0;
    end
  end

  // Transmitter load, flow character first
  always_ff @(posedge mclk) begin
    if (srst) begin
      txValid <= 1'b0;
      txData <= 8'h00;
      sentPause <= 1'b1;
    end else if (flowSend & (~txValid | txReady)) begin
      txValid <= 1'b1;
      txData <= pauseReq ? CH_XOFF : CH_XON;
      sentPause <= pauseReq;
    end else if (kqPop) begin
      txValid <= 1'b1;
      txData <= kqMem[kqRd];
    end else if (txReady) begin
      txValid <= 1'b0;
    end
  end

  // Auto repeat
  logic [CNT_W-1:0] nextPeriod;
  assign nextPeriod = (repPeriod > REP_END + REP_STEP) ? repPeriod - REP_STEP : REP_END;
  // repeat only when queue drained, so baud limits the rate
  assign repPush = repeating & (repTimer >= repPeriod) & (kqCount == 5'h00) & ~pendLf & ~pendTurn;
  always_ff @(posedge mclk) begin
    if (srst) begin
      repeating <= 1'b0;
      lastRep <= 1'b0;
      lastCode <= 8'h00;
      holdCnt <= '0;
      repTimer <= '0;
      repPeriod <= REP_START;
    end else if (keyTake) begin
      // most recent key is the candidate
      lastCode <= keyCode;
      lastRep <= keyRepeatable;
      holdCnt <= '0;
    end else if (~lastKeyHeld) begin
      repeating <= 1'b0;
      holdCnt <= '0;
    end else if (~repeating) begin
      holdCnt <= holdCnt + 1'b1;
      if (holdCnt >= REP_DELAY && lastRep && ctrl[CTL_AREP]) begin
        repeating <= 1'b1;
        repTimer <= '0;
        repPeriod <= REP_START;
      end
    end else if (repPush) begin
      repTimer <= '0;
      repPeriod <= nextPeriod;
    end else if (repTimer < repPeriod) begin
      repTimer <= repTimer + 1'b1;
    end
  end

  // warning tone on nearly full queue
  always_ff @(posedge mclk) begin
    if (srst) begin
      toneCnt <= '0;
      toneDiv <= '0;
      toneOut <= 1'b0;
    end else if (keyTake && kqCount > KQ_WARN) begin
      toneCnt <= TONE_LEN;
      toneDiv <= '0;
    end else if (toneCnt != '0) begin
      toneCnt <= toneCnt - 1'b1;
      if (toneDiv >= TONE_HALF - 1'b1) begin
        toneDiv <= '0;
        toneOut <= ~toneOut;
      end else begin
        toneDiv <= toneDiv + 1'b1;
      end
    end else begin
      toneOut <= 1'b0;
    end
  end

  // Break generation
  always_ff @(posedge mclk) begin
    if (srst) begin
      brkCnt <= '0;
      txBreak <= 1'b0;
    end else begin
      txBreak <= brkCnt != '0;
      if (breakPress && brkCnt == '0) begin
        brkCnt <= shiftHeld ? BRK_LONG : BRK_SHORT;
      end else if (brkCnt != '0) begin
        brkCnt <= brkCnt - 1'b1;
      end
    end
  end
endmodule : sfk_flow_kbd
`default_nettype wire

/* hw/sfk_pkg.sv */
/*
  Constants for the serial flow control and keyboard transmit block:
  register map, control field positions, character codes and timing.
  Assumes a single 40 MHz device clock.
*/
`default_nettype none
package sfk_pkg;
  localparam int MCLK_HZ = 40_000_000;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TURN = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  // Control field positions
  localparam int CTL_TXEN = 0;
  localparam int CTL_XONEN = 1;
  localparam int CTL_SECCH = 2;
  localparam int CTL_MODEM = 3;
  localparam int CTL_BUFLG = 4;
  localparam int CTL_AREP = 5;
  localparam int CTL_NEWLN = 6;
  localparam int CTL_CHDX = 7;
  localparam int CTL_SETUP = 8;
  localparam int CTL_LINE = 9;
  localparam int CTL_W = 10;
  localparam logic [CTL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [7:0] TURN_RST = 8'h00;
  // Status field positions
  localparam int ST_RXCNT = 0;
  localparam int ST_KQCNT = 16;
  localparam int ST_PAUSE = 24;
  localparam int ST_SRTS = 25;
  localparam int ST_BRK = 26;
  localparam int ST_REP = 27;
  // Queue sizes and water marks
  localparam int RXQ_DEPTH = 1000;
  localparam int KQ_DEPTH = 16;
  localparam logic [9:0] RX_LAST = 10'h3e7;
  localparam logic [9:0] RX_FULL = 10'h3e8;
  localparam logic [9:0] LOW_SMALL = 10'h032;
  localparam logic [9:0] HIGH_SMALL = 10'h03c;
  localparam logic [9:0] LOW_LARGE = 10'h100;
  localparam logic [9:0] HIGH_LARGE = 10'h240;
  localparam logic [4:0] KQ_FULL = 5'h10;
  localparam logic [4:0] KQ_WARN = 5'h0c;
  // Character codes
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_DEL = 8'h7f;
  localparam logic [7:0] CH_SUB = 8'h1a;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  // Times in their own units and derived cycle counts
  localparam real BRK_SHORT_MS = 233.0;
  localparam real BRK_LONG_S = 3.5;
  localparam real REP_DELAY_S = 0.6;
  localparam real REP_START_CPS = 7.5;
  localparam real REP_END_CPS = 25.0;
  localparam real REP_STEP_MS = 10.0;
  localparam real TONE_HZ = 400.0;
  localparam real TONE_LEN_MS = 100.0;
  localparam int BRK_SHORT_CYC = int'($ceil(BRK_SHORT_MS * MCLK_HZ / 1000.0));
  localparam int BRK_LONG_CYC = int'($ceil(BRK_LONG_S * MCLK_HZ));
  localparam int REP_DELAY_CYC = int'($ceil(REP_DELAY_S * MCLK_HZ));
  localparam int REP_START_CYC = int'($ceil(MCLK_HZ / REP_START_CPS));
  localparam int REP_END_CYC = int'($ceil(MCLK_HZ / REP_END_CPS));
  localparam int REP_STEP_CYC = int'($floor(REP_STEP_MS * MCLK_HZ / 1000.0));
  localparam int TONE_HALF_CYC = int'($floor(MCLK_HZ / (2.0 * TONE_HZ)));
  localparam int TONE_LEN_CYC = int'($floor(TONE_LEN_MS * MCLK_HZ / 1000.0));
  localparam int CNT_W = 28;
endpackage : sfk_pkg
`default_nettype wire

/* tb/sfk_flow_kbd_assertions.sv */
/* Port checker for sfk_flow_kbd.
   Assumes mclk with synchronous srst; bound to the design below. */
`default_nettype none
module sfk_flow_kbd_assertions
  import sfk_pkg::*;
#(
  parameter logic [CNT_W-1:0] BRK_SHORT = 28'h32,
  parameter logic [CNT_W-1:0] BRK_LONG = 28'hc8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxParityErr,
  input wire logic [7:0] prnData,
  input wire logic prnValid,
  input wire logic prnFetch,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic txBreak,
  input wire logic breakPress,
  input wire logic shiftHeld,
  input wire logic toneOut
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [CNT_W-1:0] brkCnt;
  logic brkLong;
  logic [7:0] lastRx;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Length of the current break
  always_ff @(posedge mclk) begin
    if (srst || !txBreak) brkCnt <= '0;
    else brkCnt <= brkCnt + 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (srst) brkLong <= 1'b0;
    else if (breakPress && !txBreak) brkLong <= shiftHeld;
  end
  always_ff @(posedge mclk) begin
    if (rxValid) lastRx <= rxData;
  end
  sequence s_rx_empty;
    rxValid && !prnValid && !prnFetch && !$past(rxValid) && !$past(rxValid, 2);
  endsequence
  sequence s_brk_go;
    breakPress && !txBreak;
  endsequence
  a_fill_dropped: assert property (prnValid |-> prnData != CH_NUL && prnData != CH_DEL)
    else $error("fill character reached the printer");
  a_rx_stored: assert property ((s_rx_empty ##0 (rxData != CH_NUL && rxData != CH_DEL && !rxParityErr))
    |-> ##[1:3] (prnValid && prnData == lastRx)) else $error("received character not offered");
  a_parity_sub: assert property ((s_rx_empty ##0 rxParityErr) |-> ##[1:3] (prnValid && prnData == CH_SUB))
    else $error("parity error not substituted");
  a_prn_hold: assert property (prnValid && !prnFetch |=> prnValid && $stable(prnData))
    else $error("printer head changed without fetch");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("transmit byte changed before taken");
  a_brk_start: assert property (s_brk_go |-> ##[1:3] txBreak)
    else $error("break not started");
  a_brk_short: assert property ($fell(txBreak) && !brkLong |-> brkCnt == BRK_SHORT)
    else $error("short break length wrong");
  a_brk_long: assert property ($fell(txBreak) && brkLong |-> brkCnt == BRK_LONG)
    else $error("long break length wrong");
  a_tone_half: assert property ($rose(toneOut) |-> toneOut[*4] ##1 !toneOut)
    else $error("tone half period wrong");
endmodule : sfk_flow_kbd_assertions

bind sfk_flow_kbd sfk_flow_kbd_assertions #(.BRK_SHORT(BRK_SHORT), .BRK_LONG(BRK_LONG)) chk_u (
  .mclk(mclk), .srst(srst), .rxValid(rxValid), .rxData(rxData), .rxParityErr(rxParityErr),
  .prnData(prnData), .prnValid(prnValid), .prnFetch(prnFetch), .txData(txData), .txValid(txValid),
  .txReady(txReady), .txBreak(txBreak), .breakPress(breakPress), .shiftHeld(shiftHeld), .toneOut(toneOut)
);
`default_nettype wire

/* tb/sfk_flow_kbd_test.sv */
/* Self-checking bench for sfk_flow_kbd with shortened counts.
   Assumes sfk_host_model on the serial side and AXI4-Lite register access. */
`default_nettype none
module sfk_flow_kbd_test
  import sfk_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BS = 50;
  localparam int BL = 200;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, keyCode = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic prnFetch = 1'b0, keyPress = 1'b0, keyRep = 1'b0, keyRet = 1'b0, held = 1'b0;
  logic brkPress = 1'b0, shift = 1'b0;
  logic [2:0] flt = 3'h0;
  logic [7:0] codes[6] = '{8'h0a, 8'h08, 8'h09, 8'h20, 8'h7f, 8'h1b};
  wire logic awready, wready, bvalid, arready, rvalid, rxValid, rxPe, prnValid;
  wire logic txValid, txReady, txBreak, srts, toneOut, paused;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0] rxData, prnData, txData;
  int err_count = 0;
  int n_compared = 0;
  sfk_flow_kbd #(.BRK_SHORT(28'(BS)), .BRK_LONG(28'(BL)), .REP_DELAY(28'h14), .REP_START(28'h28),
    .REP_END(28'ha), .TONE_HALF(28'h4)) dut_u (
    .mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxValid(rxValid), .rxData(rxData), .rxParityErr(rxPe),
    .prnData(prnData), .prnValid(prnValid), .prnFetch(prnFetch), .paperOut(flt[0]), .headJam(flt[1]),
    .coverOpen(flt[2]), .txData(txData), .txValid(txValid), .txReady(txReady), .txBreak(txBreak),
    .srts(srts), .keyPress(keyPress), .keyCode(keyCode), .keyRepeatable(keyRep), .keyIsReturn(keyRet),
    .lastKeyHeld(held), .breakPress(brkPress), .shiftHeld(shift), .toneOut(toneOut)
  );
  sfk_host_model host_u (
    .mclk(mclk), .txData(txData), .txValid(txValid), .txReady(txReady), .srts(srts),
    .rxValid(rxValid), .rxData(rxData), .rxParityErr(rxPe), .paused(paused)
  );
  initial forever #12.5 mclk = ~mclk;
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic fail_wait;
    chk(32'h0, 32'h1);
    finish_test();
  endtask : fail_wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) fail_wait();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) fail_wait();
  endtask : rd
  task automatic key(input logic [7:0] c, input logic rep, input logic ret);
    @(posedge mclk);
    keyPress <= 1'b1;
    keyCode <= c;
    keyRep <= rep;
    keyRet <= ret;
    @(posedge mclk);
    keyPress <= 1'b0;
  endtask : key
  task automatic exp_tx(input logic [7:0] e);
    int n;
    for (n = 0; n < 2000 && host_u.got.size() == 0; n++) @(posedge mclk);
    if (n == 2000) fail_wait();
    chk(32'(host_u.got.pop_front()), 32'(e));
  endtask : exp_tx
  task automatic fetch(input logic [7:0] e);
    int n;
    for (n = 0; n < 20 && prnValid !== 1'b1; n++) @(posedge mclk);
    if (n == 20) fail_wait();
    chk(32'(prnData), 32'(e));
    prnFetch <= 1'b1;
    @(posedge mclk);
    prnFetch <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : fetch
  task automatic brk(input logic sh, input int len);
    int n;
    int c;
    @(posedge mclk);
    brkPress <= 1'b1;
    shift <= sh;
    @(posedge mclk);
    brkPress <= 1'b0;
    for (n = 0; n < 10 && txBreak !== 1'b1; n++) @(posedge mclk);
    for (c = 0; c < 1000 && txBreak === 1'b1; c++) @(posedge mclk);
    chk(32'(c), 32'(len));
    shift <= 1'b0;
  endtask : brk
  task automatic flow(input logic [31:0] cfg, input int hi, input int lo, input logic first);
    int s;
    logic [1:0] r;
    wr(REG_CTRL, cfg, r);
    if (first) exp_tx(CH_XON);
    for (s = 0; s < 1000 && paused !== 1'b1; s++) host_u.send(8'h41, 1'b0);
    exp_tx(CH_XOFF);
    chk(32'(s > hi && s < hi + 8), 32'h1);
    repeat (s - lo - 1) fetch(8'h41);
    repeat (20) @(posedge mclk);
    chk(32'(host_u.got.size()), 32'h0);
    fetch(8'h41);
    exp_tx(CH_XON);
    repeat (lo) fetch(8'h41);
  endtask : flow
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int i;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(REG_CTRL, d, r);
    chk(d, 32'(CTRL_RST));
    rd(8'h0c, d, r);
    chk(32'(r), 32'h2);
    wr(8'h10, 32'h1, r);
    chk(32'(r), 32'h2);
    wr(REG_TURN, 32'h03, r);
    // Upper lanes only: the turnaround byte must not move
    wstrb <= 4'he;
    wr(REG_TURN, 32'h55, r);
    wstrb <= 4'hf;
    rd(REG_TURN, d, r);
    chk(d, 32'h03);
    $display("test registers done");
    host_u.send(8'h42, 1'b1);
    host_u.send(8'h41, 1'b0);
    host_u.send(CH_NUL, 1'b0);
    host_u.send(CH_DEL, 1'b0);
    host_u.send(8'h43, 1'b0);
    fetch(CH_SUB);
    fetch(8'h41);
    fetch(8'h43);
    // One character sits in the printer head, so 1002 overflow the queue by one
    for (i = 0; i < 1002; i++) host_u.send(8'h41, 1'b0);
    rd(REG_STAT, d, r);
    chk(32'(d[9:0]), 32'(RX_FULL));
    repeat (1001) fetch(8'h41);
    fetch(CH_SUB);
    $display("test receive done");
    flow(32'h03, 60, 50, 1'b1);
    flow(32'h13, 576, 256, 1'b0);
    for (i = 0; i < 3; i++) begin
      flt <= 3'(1 << i);
      exp_tx(CH_XOFF);
      flt <= 3'h0;
      exp_tx(CH_XON);
    end
    wr(REG_CTRL, 32'h113, r);
    exp_tx(CH_XOFF);
    wr(REG_CTRL, 32'h013, r);
    exp_tx(CH_XON);
    wr(REG_CTRL, 32'h05, r);
    flt <= 3'h1;
    repeat (10) @(posedge mclk);
    chk(32'(srts), 32'h1);
    wr(REG_CTRL, 32'h0d, r);
    repeat (10) @(posedge mclk);
    chk(32'(srts), 32'h0);
    flt <= 3'h0;
    repeat (10) @(posedge mclk);
    chk(32'(srts), 32'h1);
    $display("test flow done");
    host_u.slow <= 1'b1;
    wr(REG_CTRL, 32'h0, r);
    key(8'h61, 1'b0, 1'b0);
    key(8'h62, 1'b0, 1'b0);
    wr(REG_CTRL, 32'h1, r);
    exp_tx(8'h61);
    exp_tx(8'h62);
    foreach (codes[j]) begin
      key(codes[j], 1'b0, 1'b0);
      exp_tx(codes[j]);
    end
    wr(REG_CTRL, 32'hc1, r);
    key(CH_CR, 1'b0, 1'b1);
    exp_tx(CH_CR);
    exp_tx(CH_LF);
    exp_tx(8'h03);
    wr(REG_CTRL, 32'h21, r);
    key(8'h70, 1'b1, 1'b0);
    key(8'h78, 1'b1, 1'b0);
    held <= 1'b1;
    exp_tx(8'h70);
    repeat (3) exp_tx(8'h78);
    key(8'h79, 1'b1, 1'b0);
    repeat (2) exp_tx(8'h78);
    held <= 1'b0;
    repeat (200) @(posedge mclk);
    while (host_u.got.size() > 0) exp_tx(8'h78);
    $display("test keys done");
    wr(REG_CTRL, 32'h0, r);
    for (i = 0; i < 13; i++) key(8'h6b, 1'b0, 1'b0);
    repeat (10) @(posedge mclk);
    chk(32'(toneOut), 32'h0);
    key(8'h6b, 1'b0, 1'b0);
    for (i = 0; i < 20 && toneOut !== 1'b1; i++) @(posedge mclk);
    chk(32'(toneOut), 32'h1);
    rd(REG_STAT, d, r);
    chk(32'(d[20:16]), 32'd14);
    wr(REG_CTRL, 32'h100, r);
    rd(REG_STAT, d, r);
    chk(32'(d[20:16]), 32'h0);
    wr(REG_CTRL, 32'h0, r);
    repeat (3) key(8'h6b, 1'b0, 1'b0);
    wr(REG_CTRL, 32'h200, r);
    rd(REG_STAT, d, r);
    chk(32'(d[20:16]), 32'h0);
    repeat (2) key(8'h6b, 1'b0, 1'b0);
    brk(1'b0, BS);
    rd(REG_STAT, d, r);
    chk(32'(d[20:16]), 32'h0);
    brk(1'b1, BL);
    wr(REG_CTRL, 32'h201, r);
    repeat (100) @(posedge mclk);
    chk(32'(host_u.got.size()), 32'h0);
    $display("test queue and break done");
    finish_test();
  end
endmodule : sfk_flow_kbd_test
`default_nettype wire

/* tb/sfk_host_model.sv */
/* Remote data source: sends characters, takes transmit bytes, flags pause.
   Assumes the bench calls send just after a clock edge. */
`default_nettype none
module sfk_host_model
  import sfk_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  input wire logic srts,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxParityErr,
  output logic paused
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  logic slow = 1'b0;
  logic xoffSeen = 1'b0;
  initial begin
    txReady = 1'b0;
    rxValid = 1'b0;
    rxData = 8'h00;
    rxParityErr = 1'b0;
  end
  // hold off after pause until resume
  assign paused = xoffSeen || !srts;
  always @(posedge mclk) begin
    txReady <= slow ? ~txReady : 1'b1;
    if (txValid && txReady) begin
      got.push_back(txData);
      if (txData === CH_XOFF) xoffSeen <= 1'b1;
      if (txData === CH_XON) xoffSeen <= 1'b0;
    end
  end
  task automatic send(input logic [7:0] c, input logic pe);
    @(posedge mclk);
    rxValid <= 1'b1;
    rxData <= c;
    rxParityErr <= pe;
    @(posedge mclk);
    rxValid <= 1'b0;
    rxData <= ~c;
    rxParityErr <= 1'b0;
  endtask : send
endmodule : sfk_host_model
`default_nettype wire
